//--- cbr_agu.sv
// Purpose: circular and bit-reversed effective address generation
// Assumes: one request per generator per cycle, answer one cycle later
// Notes: x read, x write and y generators share the same wrap function
//
// Local design decisions: the strobed register port and the register offsets.
`include "cbr_defs.svh"
module cbr_agu #(
    parameter int unsigned AW = 3
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire logic [AW-1:0]     i_addr,
    input  wire logic [15:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [15:0]       o_rdata,
    input  wire cbr_pkg::cbr_req_s i_xr_req,
    input  wire cbr_pkg::cbr_req_s i_xw_req,
    input  wire cbr_pkg::cbr_req_s i_y_req,
    output cbr_pkg::cbr_res_s      o_xr_res,
    output cbr_pkg::cbr_res_s      o_xw_res,
    output cbr_pkg::cbr_res_s      o_y_res
);
    logic [15:0] ctrl;
    logic [15:0] x_start;
    logic [15:0] x_end;
    logic [15:0] y_start;
    logic [15:0] y_end;
    logic [15:0] brev;
    logic [3:0]  xsel;
    logic [3:0]  ysel;
    logic [3:0]  bsel;
    logic        x_circ;
    logic        y_circ;
    logic        b_on;
    logic        xw_brev;
    cbr_pkg::cbr_res_s next_xr;
    cbr_pkg::cbr_res_s next_xw;
    cbr_pkg::cbr_res_s next_y;

    // reverse bit order of a 16-bit word
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    // reverse-carry add: carries run from msb toward lsb
    function automatic logic [15:0] rev_add(input logic [15:0] a,
                                            input logic [15:0] b);
        return rev16(rev16(a) + rev16(b));
    endfunction

    // common wrap logic; circ selects modulo correction
    function automatic cbr_pkg::cbr_res_s agen(
        input cbr_pkg::cbr_req_s q,
        input logic              circ,
        input logic [15:0]       st,
        input logic [15:0]       en,
        input logic              word
    );
        cbr_pkg::cbr_res_s r;
        logic [15:0] len;
        logic [15:0] nxt;
        logic        up;
        logic        pre;
        len = en - st + 16'h0001;
        up  = 1'b1;
        pre = 1'b0;
        unique case (q.mode)
            cbr_pkg::CBR_IND: begin
                nxt = q.ptr;
            end
            cbr_pkg::CBR_POST_INC: begin
                nxt = q.ptr + q.step;
            end
            cbr_pkg::CBR_PRE_INC: begin
                nxt = q.ptr + q.step;
                pre = 1'b1;
            end
            cbr_pkg::CBR_POST_DEC: begin
                nxt = q.ptr - q.step;
                up  = 1'b0;
            end
            cbr_pkg::CBR_PRE_DEC: begin
                nxt = q.ptr - q.step;
                up  = 1'b0;
                pre = 1'b1;
            end
            cbr_pkg::CBR_REG_OFS: begin
                nxt = q.ptr + q.step;
                up  = ~q.step[15];
                pre = 1'b1;
            end
            default: begin
                nxt = q.ptr;
            end
        endcase
        // direction picks the checked limit; works both ways for a buffer longer than the step while pointer plus or minus step stays within 16 bits
        if (circ && q.mode != cbr_pkg::CBR_IND) begin
            if (up && nxt > en) begin
                nxt = nxt - len;
            end else if (!up && nxt < st) begin
                nxt = nxt + len;
            end
        end
        r.valid   = q.valid;
        r.ea      = pre ? nxt : q.ptr;
        r.new_ptr = nxt;
        // offset mode uses the wrapped address but keeps the pointer
        r.wb = q.mode != cbr_pkg::CBR_IND &&
               q.mode != cbr_pkg::CBR_REG_OFS;
        if (word) begin
            r.ea[0]      = 1'b0;
            r.new_ptr[0] = 1'b0;
        end
        return r;
    endfunction

    // control fields
    assign xsel = ctrl[`CBR_XSEL_LSB +: 4];
    assign ysel = ctrl[`CBR_YSEL_LSB +: 4];
    assign bsel = ctrl[`CBR_BSEL_LSB +: 4];
    assign x_circ = ctrl[`CBR_XEN_BIT] && xsel != `CBR_SEL_OFF;
    assign y_circ = ctrl[`CBR_YEN_BIT] && ysel != `CBR_SEL_OFF;
    assign b_on = brev[`CBR_BITREV_ENABLE_BIT] && bsel != `CBR_SEL_OFF;

    // bitrev only for word writes through the chosen pointer
    assign xw_brev = b_on && i_xw_req.sel == bsel && !i_xw_req.byte_op &&
                     (i_xw_req.mode == cbr_pkg::CBR_POST_INC ||
                      i_xw_req.mode == cbr_pkg::CBR_PRE_INC);

    // x read: circular only on the xsel pointer, one buffer per space
    always_comb begin
        next_xr = agen(i_xr_req, x_circ && i_xr_req.sel == xsel,
                       x_start, x_end, 1'b0);
    end

    // x write: bitrev overrides and shuts off circular mode
    always_comb begin
        next_xw = agen(i_xw_req, x_circ && !b_on && i_xw_req.sel == xsel,
                       x_start, x_end, 1'b0);
        if (xw_brev) begin
            next_xw.new_ptr = rev_add(i_xw_req.ptr,
                                      {brev[14:0], 1'b0});
            next_xw.new_ptr[0] = 1'b0;
            next_xw.ea = i_xw_req.mode == cbr_pkg::CBR_PRE_INC ?
                         next_xw.new_ptr : {i_xw_req.ptr[15:1], 1'b0};
            next_xw.wb = 1'b1;
        end
    end

    // y: circular only, never bit reversed, word aligned while y circular is on
    always_comb begin
        next_y = agen(i_y_req, y_circ && i_y_req.sel == ysel,
                      y_start, y_end, y_circ);
    end

    // register writes; values steer agen from the next cycle on
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl    <= `CBR_RST_VAL;
            x_start <= `CBR_RST_VAL;
            x_end   <= `CBR_RST_VAL;
            y_start <= `CBR_RST_VAL;
            y_end   <= `CBR_RST_VAL;
            brev    <= `CBR_RST_VAL;
        end else if (i_wr) begin
            unique case (i_addr)
                `CBR_A_CTRL:   ctrl    <= i_wdata;
                `CBR_A_XSTART: x_start <= i_wdata;
                `CBR_A_XEND:   x_end   <= i_wdata;
                `CBR_A_YSTART: y_start <= i_wdata;
                `CBR_A_YEND:   y_end   <= i_wdata;
                `CBR_A_BREV:   brev    <= i_wdata;
                default: ; // unmapped writes are dropped
            endcase
        end
    end

    // read data stands one cycle only, zero otherwise
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            unique case (i_addr)
                `CBR_A_CTRL:   o_rdata <= ctrl;
                `CBR_A_XSTART: o_rdata <= x_start;
                `CBR_A_XEND:   o_rdata <= x_end;
                `CBR_A_YSTART: o_rdata <= y_start;
                `CBR_A_YEND:   o_rdata <= y_end;
                `CBR_A_BREV:   o_rdata <= brev;
                default:       o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // results registered so every output comes from a flop
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_xr_res <= '0;
            o_xw_res <= '0;
            o_y_res  <= '0;
        end else begin
            o_xr_res <= next_xr;
            o_xw_res <= next_xw;
            o_y_res  <= next_y;
        end
    end

    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    rd_window_a: assert property (
        !$past(i_rd) |-> o_rdata == 16'h0000
    ) else $error("read data outside its cycle");

    rd_ctrl_a: assert property (
        i_rd && i_addr == `CBR_A_CTRL && !i_wr |=> o_rdata == $past(ctrl)
    ) else $error("control readback wrong");

    ofs_no_wb_a: assert property (
        i_xr_req.mode == cbr_pkg::CBR_REG_OFS |=> !o_xr_res.wb
    ) else $error("offset mode wrote pointer back");

    post_wb_a: assert property (
        i_y_req.mode == cbr_pkg::CBR_POST_INC |=>
            o_y_res.wb && o_y_res.ea[15:1] == $past(i_y_req.ptr[15:1])
    ) else $error("post modify wrong");

    y_word_a: assert property (
        y_circ |=> !o_y_res.ea[0] && !o_y_res.new_ptr[0]
    ) else $error("y circular address odd");

    x_wrap_up_a: assert property (
        x_circ && i_xr_req.sel == xsel &&
        i_xr_req.mode == cbr_pkg::CBR_POST_INC &&
        i_xr_req.ptr >= x_start && i_xr_req.ptr <= x_end &&
        i_xr_req.step < x_end - x_start + 16'h0001 |=>
            o_xr_res.new_ptr >= $past(x_start) &&
            o_xr_res.new_ptr <= $past(x_end)
    ) else $error("x pointer left buffer");

    x_off_a: assert property (
        xsel == `CBR_SEL_OFF && i_xr_req.mode == cbr_pkg::CBR_PRE_DEC |=>
            o_xr_res.ea == $past(i_xr_req.ptr) - $past(i_xr_req.step)
    ) else $error("select 15 still wraps");

    // reversed result checked through the inverse arrangement
    brev_sum_a: assert property (
        xw_brev |=> o_xw_res.wb &&
            rev16(o_xw_res.new_ptr) ==
            ((rev16($past(i_xw_req.ptr)) +
              rev16({$past(brev[14:0]), 1'b0})) & 16'h7fff)
    ) else $error("bitrev result wrong");

    // bitrev on already shuts x write circular off for every pointer
    brev_byte_a: assert property (
        b_on && i_xw_req.byte_op &&
        i_xw_req.mode == cbr_pkg::CBR_POST_INC |=>
            o_xw_res.new_ptr == $past(i_xw_req.ptr) + $past(i_xw_req.step)
    ) else $error("byte write was bit reversed");

    y_no_brev_a: assert property (
        !y_circ && i_y_req.mode == cbr_pkg::CBR_PRE_INC |=>
            o_y_res.ea == $past(i_y_req.ptr) + $past(i_y_req.step)
    ) else $error("y address altered");

    y_ind_a: assert property (
        y_circ && i_y_req.mode == cbr_pkg::CBR_IND |=>
            o_y_res.ea == {$past(i_y_req.ptr[15:1]), 1'b0} && !o_y_res.wb
    ) else $error("y indirect address wrong");

    // generator checks: limits, write back, address choice and valid copy
    x_wrap_dn_a: assert property (
        x_circ && i_xr_req.sel == xsel &&
        i_xr_req.mode == cbr_pkg::CBR_POST_DEC &&
        i_xr_req.ptr >= x_start && i_xr_req.ptr <= x_end &&
        i_xr_req.step <= i_xr_req.ptr &&
        i_xr_req.step < x_end - x_start + 16'h0001 |=>
            o_xr_res.new_ptr >= $past(x_start) &&
            o_xr_res.new_ptr <= $past(x_end)
    ) else $error("x pointer left buffer going down");

    wb_modes_a: assert property (
        i_xr_req.mode inside {cbr_pkg::CBR_POST_INC, cbr_pkg::CBR_POST_DEC,
                              cbr_pkg::CBR_PRE_INC, cbr_pkg::CBR_PRE_DEC}
        |=> o_xr_res.wb
    ) else $error("modify mode lost write back");

    ind_ea_a: assert property (
        i_xr_req.mode == cbr_pkg::CBR_IND |=>
            o_xr_res.ea == $past(i_xr_req.ptr) && !o_xr_res.wb
    ) else $error("plain indirect changed address");

    pre_ea_a: assert property (
        i_xr_req.mode == cbr_pkg::CBR_PRE_DEC |=>
            o_xr_res.ea == o_xr_res.new_ptr
    ) else $error("pre modify address differs");

    xr_valid_a: assert property (
        o_xr_res.valid == $past(i_xr_req.valid)
    ) else $error("x read valid not copied");

    xw_valid_a: assert property (
        o_xw_res.valid == $past(i_xw_req.valid)
    ) else $error("x write valid not copied");

    y_valid_a: assert property (
        o_y_res.valid == $past(i_y_req.valid)
    ) else $error("y valid not copied");

    // bit reverse checks on the x write generator
    brev_ea_a: assert property (
        xw_brev |=> o_xw_res.wb && !o_xw_res.ea[0]
    ) else $error("bitrev address odd");

    brev_post_a: assert property (
        xw_brev && i_xw_req.mode == cbr_pkg::CBR_POST_INC |=>
            o_xw_res.ea == {$past(i_xw_req.ptr[15:1]), 1'b0}
    ) else $error("bitrev pointer not in normal order");

    brev_pre_a: assert property (
        xw_brev && i_xw_req.mode == cbr_pkg::CBR_PRE_INC |=>
            o_xw_res.ea == o_xw_res.new_ptr
    ) else $error("bitrev pre address wrong");

    xw_no_circ_a: assert property (
        b_on && i_xw_req.mode == cbr_pkg::CBR_POST_DEC |=>
            o_xw_res.new_ptr == $past(i_xw_req.ptr) - $past(i_xw_req.step)
    ) else $error("x write wrapped while bitrev on");

    // register port checks
    wr_ctrl_a: assert property (
        i_wr && i_addr == `CBR_A_CTRL |=> ctrl == $past(i_wdata)
    ) else $error("control write lost");

    wr_drop_a: assert property (
        i_wr && i_addr >= 3'h6 |=> $stable(ctrl) && $stable(x_start) &&
            $stable(x_end) && $stable(y_start) && $stable(y_end) &&
            $stable(brev)
    ) else $error("unmapped write changed a register");

    rd_xstart_a: assert property (
        i_rd && i_addr == `CBR_A_XSTART && !i_wr |=>
            o_rdata == $past(x_start)
    ) else $error("x start readback wrong");

    rd_xend_a: assert property (
        i_rd && i_addr == `CBR_A_XEND && !i_wr |=>
            o_rdata == $past(x_end)
    ) else $error("x end readback wrong");

    rd_ystart_a: assert property (
        i_rd && i_addr == `CBR_A_YSTART && !i_wr |=>
            o_rdata == $past(y_start)
    ) else $error("y start readback wrong");

    rd_yend_a: assert property (
        i_rd && i_addr == `CBR_A_YEND && !i_wr |=>
            o_rdata == $past(y_end)
    ) else $error("y end readback wrong");

    rd_brev_a: assert property (
        i_rd && i_addr == `CBR_A_BREV && !i_wr |=>
            o_rdata == $past(brev)
    ) else $error("modifier readback wrong");
endmodule

//--- cbr_core_model.sv
// Purpose: core-side pointer holder for the x write generator
// Assumes: one request, then its result, before the next request
// Notes: pointer comes from its own register so write-back is exercised
module cbr_core_model (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire logic              i_load,
    input  wire cbr_pkg::cbr_req_s i_cmd,
    input  wire cbr_pkg::cbr_res_s i_res,
    output cbr_pkg::cbr_req_s      o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ptr;

    // pointer changes only on a load or when the generator writes back
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ptr <= 16'h0000;
        end else if (i_load) begin
            ptr <= i_cmd.ptr;
        end else if (i_res.valid && i_res.wb) begin
            ptr <= i_res.new_ptr;
        end
    end

    // request fields from the command, pointer from the held register
    always_comb begin
        o_req     = i_cmd;
        o_req.ptr = ptr;
    end
endmodule

//--- cbr_defs.svh
// Purpose: offsets, field positions, reset values for circular/bitrev agu
// Assumes: register port with word index addressing, 16-bit data
// Notes: one index per register, indices 6 and 7 are unmapped
`ifndef CBR_DEFS_SVH
`define CBR_DEFS_SVH
`define CBR_A_CTRL   3'h0
`define CBR_A_XSTART 3'h1
`define CBR_A_XEND   3'h2
`define CBR_A_YSTART 3'h3
`define CBR_A_YEND   3'h4
`define CBR_A_BREV   3'h5
`define CBR_RST_VAL  16'h0000
`define CBR_XSEL_LSB 0
`define CBR_YSEL_LSB 4
`define CBR_BSEL_LSB 8
`define CBR_XEN_BIT  15
`define CBR_YEN_BIT  14
`define CBR_BITREV_ENABLE_BIT 15
`define CBR_SEL_OFF  4'hf
`endif

//--- cbr_pkg.sv
// Purpose: types for the circular/bitrev address generators
// Assumes: 16-bit data addresses, 16 working registers
// Notes: step is a magnitude for inc/dec, two's complement for reg offset
package cbr_pkg;
    typedef enum logic [2:0] {
        CBR_IND,
        CBR_POST_INC,
        CBR_POST_DEC,
        CBR_PRE_INC,
        CBR_PRE_DEC,
        CBR_REG_OFS
    } cbr_mode_e;

    typedef struct packed {
        logic        valid;
        logic [3:0]  sel;
        logic [15:0] ptr;
        cbr_mode_e   mode;
        logic [15:0] step;
        logic        byte_op;
    } cbr_req_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] ea;
        logic        wb;
        logic [15:0] new_ptr;
    } cbr_res_s;
endpackage

//--- circular_and_bitrev_addressing_tb.sv
// Purpose: self-checking bench for the circular/bitrev generators
// Assumes: register indices and one-cycle latencies of the design
// Notes: x write requests pass through the core model for write-back
`include "cbr_defs.svh"
module circular_and_bitrev_addressing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam cbr_pkg::cbr_mode_e IND  = cbr_pkg::CBR_IND;
    localparam cbr_pkg::cbr_mode_e PINC = cbr_pkg::CBR_POST_INC;
    localparam cbr_pkg::cbr_mode_e PDEC = cbr_pkg::CBR_POST_DEC;
    localparam cbr_pkg::cbr_mode_e RINC = cbr_pkg::CBR_PRE_INC;
    localparam cbr_pkg::cbr_mode_e RDEC = cbr_pkg::CBR_PRE_DEC;
    localparam cbr_pkg::cbr_mode_e ROFS = cbr_pkg::CBR_REG_OFS;
    logic              i_sys_clk = 1'b0;
    logic              i_rst     = 1'b1;
    logic [2:0]        i_addr    = 3'h0;
    logic [15:0]       i_wdata   = 16'h0000;
    logic              i_wr      = 1'b0;
    logic              i_rd      = 1'b0;
    logic              ld        = 1'b0;
    logic              bop       = 1'b0;
    logic [15:0]       o_rdata;
    logic [15:0]       prev;
    logic [15:0]       nxt;
    cbr_pkg::cbr_req_s xr        = '0;
    cbr_pkg::cbr_req_s yq        = '0;
    cbr_pkg::cbr_req_s cmd       = '0;
    cbr_pkg::cbr_req_s xw;
    cbr_pkg::cbr_res_s res[3];
    int                errors    = 0;
    int                checks    = 0;

    // 100 MHz clock
    always #5 i_sys_clk = ~i_sys_clk;

    cbr_agu #(.AW(3)) i_cbr_agu (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_addr    (i_addr),
        .i_wdata   (i_wdata),
        .i_wr      (i_wr),
        .i_rd      (i_rd),
        .o_rdata   (o_rdata),
        .i_xr_req  (xr),
        .i_xw_req  (xw),
        .i_y_req   (yq),
        .o_xr_res  (res[0]),
        .o_xw_res  (res[1]),
        .o_y_res   (res[2])
    );

    cbr_core_model i_cbr_core_model (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_load    (ld),
        .i_cmd     (cmd),
        .i_res     (res[1]),
        .o_req     (xw)
    );

    function automatic logic [3:0] rev4(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // new pointer is a don't-care when no write-back is expected
    task automatic chk_res(input cbr_pkg::cbr_res_s g,
                           input cbr_pkg::cbr_res_s e);
        checks++;
        if ({g.valid, g.ea, g.wb} !== {e.valid, e.ea, e.wb} ||
            (e.wb && g.new_ptr !== e.new_ptr)) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge i_sys_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, e);
    endtask

    task automatic load(input logic [15:0] p);
        @(posedge i_sys_clk);
        ld      <= 1'b1;
        cmd.ptr <= p;
        @(posedge i_sys_clk);
        ld <= 1'b0;
    endtask

    // one request on lane ln, result checked in the cycle it stands
    task automatic gen(input int ln, input logic [3:0] s,
                       input logic [15:0] p, input cbr_pkg::cbr_mode_e m,
                       input logic [15:0] st, input logic [15:0] ea,
                       input logic wb, input logic [15:0] np);
        cbr_pkg::cbr_req_s q;
        q = '{1'b1, s, p, m, st, bop};
        @(posedge i_sys_clk);
        case (ln)
            0: xr <= q;
            1: cmd <= q;
            default: yq <= q;
        endcase
        @(posedge i_sys_clk);
        xr.valid  <= 1'b0;
        cmd.valid <= 1'b0;
        yq.valid  <= 1'b0;
        #1;
        chk_res(res[ln], '{1'b1, ea, wb, np});
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], 16'h0000);
        end
        for (int a = 0; a < 8; a++) begin
            wr(a[2:0], {13'h1a5a, a[2:0]});
        end
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], a < 6 ? {13'h1a5a, a[2:0]} : 16'h0000);
        end
        $display("test registers done");
        wr(`CBR_A_XSTART, 16'h1100);
        wr(`CBR_A_XEND, 16'h1163);
        wr(`CBR_A_CTRL, 16'h8001);
        gen(0,4'h1,16'h1162,PINC,16'h2,16'h1162,1'b1,16'h1100);
        gen(0,4'h1,16'h1160,PINC,16'h6,16'h1160,1'b1,16'h1102);
        gen(0,4'h1,16'h1100,RDEC,16'h2,16'h1162,1'b1,16'h1162);
        gen(0,4'h1,16'h1162,ROFS,16'h4,16'h1102,1'b0,16'h0000);
        gen(0,4'h1,16'h1170,IND,16'h2,16'h1170,1'b0,16'h0000);
        gen(0,4'h2,16'h1162,PINC,16'h2,16'h1162,1'b1,16'h1164);
        wr(`CBR_A_CTRL, 16'h800f);
        gen(0,4'hf,16'h1162,PINC,16'h2,16'h1162,1'b1,16'h1164);
        gen(0,4'hf,16'h1100,RDEC,16'h2,16'h10fe,1'b1,16'h10fe);
        wr(`CBR_A_CTRL, 16'h0001);
        gen(0,4'h1,16'h1162,PINC,16'h2,16'h1162,1'b1,16'h1164);
        wr(`CBR_A_CTRL, 16'h8001);
        wr(`CBR_A_XSTART, 16'h1000);
        wr(`CBR_A_XEND, 16'h101f);
        gen(0,4'h1,16'h1000,PDEC,16'h2,16'h1000,1'b1,16'h101e);
        gen(0,4'h1,16'h101e,PINC,16'h2,16'h101e,1'b1,16'h1000);
        gen(0,4'h1,16'h101e,RINC,16'h2,16'h1000,1'b1,16'h1000);
        gen(0,4'h1,16'h1000,ROFS,16'hfffc,16'h101c,1'b0,16'h0000);
        $display("test x circular done");
        wr(`CBR_A_YSTART, 16'h2000);
        wr(`CBR_A_YEND, 16'h200f);
        wr(`CBR_A_CTRL, 16'h4010);
        gen(2,4'h1,16'h200e,PINC,16'h2,16'h200e,1'b1,16'h2000);
        gen(2,4'h1,16'h2003,IND,16'h2,16'h2002,1'b0,16'h0000);
        wr(`CBR_A_CTRL, 16'h40f0);
        gen(2,4'hf,16'h200e,PINC,16'h2,16'h200e,1'b1,16'h2010);
        $display("test y circular done");
        // both modes on: x write reverses, x read keeps wrapping
        wr(`CBR_A_CTRL, 16'h8101);
        wr(`CBR_A_BREV, 16'h8008);
        load(16'h1000);
        prev = 16'h1000;
        for (int k = 1; k < 16; k++) begin
            nxt = {11'h080, rev4(k[3:0]), 1'b0};
            gen(1,4'h1,prev,PINC,16'h2,prev,1'b1,nxt);
            prev = nxt;
        end
        gen(0,4'h1,16'h1000,PINC,16'h2,16'h1000,1'b1,16'h1002);
        gen(2,4'h1,16'h2000,RINC,16'h2,16'h2002,1'b1,16'h2002);
        load(16'h1000);
        gen(1,4'h1,16'h1000,RINC,16'h2,16'h1010,1'b1,16'h1010);
        load(16'h1000);
        gen(1,4'h1,16'h1000,PDEC,16'h2,16'h1000,1'b1,16'h0ffe);
        bop = 1'b1;
        load(16'h1000);
        gen(1,4'h1,16'h1000,PINC,16'h1,16'h1000,1'b1,16'h1001);
        bop = 1'b0;
        $display("test bit reverse done");
        report_and_stop();
    end
endmodule
